// file: design/tws_defs.svh
// Offsets, field positions, reset values and timing of the two-wire bus block
// Notes on behaviour
// - Byte done flag sets at byte end
// - Data access in active direction clears it
// - Address or general call match sets slave flag
// - First control write clears slave flag
// - Busy follows start and stop conditions
// - Arbitration lost sticky until written one
// - Slave direction bit shows calling R/W
// - Interrupt pending on done, match, loss
// - Ninth bit acknowledge recorded after transmit
// - Data write starts transmit, MSB first
// - Data read starts next master reception
// - Slave transfers only after address match
// - Direction must match the data access
// - Data read returns last received byte
// - First write after master is address
// - Control2 bit 7 enables general call
// - Control2 bit 6 selects 10-bit addressing
// - Bits 1-0 give upper 10-bit address
// - Lines only pulled low or released
// - Start, address, data, then stop
// - Start is SDA fall, SCL high
// - Stop is SDA rise, SCL high
// - Ninth clock carries receiver acknowledge
// - Lost master releases SDA, becomes slave
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH
`define TWS_OFS_STATUS    8'h00
`define TWS_OFS_DATA      8'h04
`define TWS_OFS_CTRL2     8'h08
`define TWS_OFS_CTRL1     8'h0c
`define TWS_OFS_SLVADR    8'h10
`define TWS_ST_DONE       7
`define TWS_ST_ASLV       6
`define TWS_ST_BUSY       5
`define TWS_ST_ARB        4
`define TWS_ST_DIR        2
`define TWS_ST_IRQ        1
`define TWS_ST_ACK        0
`define TWS_C1_EN         7
`define TWS_C1_MST        5
`define TWS_C1_TX         4
`define TWS_C1_TXAK       3
`define TWS_C2_GCE        7
`define TWS_C2_WIDE       6
`define TWS_DONE_RST      1'b1
`define TWS_TEN_HDR       5'h1e
`define TWS_CLK_NS        100
`define TWS_SCL_HALF_NS   5000
`define TWS_SCL_HALF_CYC  ((`TWS_SCL_HALF_NS) / (`TWS_CLK_NS))
`endif

// file: design/tws_pkg.sv
// Types shared by the two-wire bus block
package tws_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } tws_apb_req_s;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tws_apb_rsp_s;
    typedef struct packed {
        logic sda;
        logic scl;
    } tws_pin_in_s;
    typedef struct packed {
        logic sdaO;
        logic sdaOe_n;
        logic sclO;
        logic sclOe_n;
    } tws_pin_out_s;
    typedef enum logic [2:0] {
        G_IDLE, G_START, G_LOW, G_HIGH, G_STOP1, G_STOP2
    } tws_gen_e;
    typedef struct packed {
        logic sdaS1, sdaS2, sdaQ, sclS1, sclS2, sclQ;
        logic en, masterSel, tx, txak, genCallEn, wideAddrSel;
        logic [2:0] adHi;
        logic [7:0] slvAdr;
        logic byteDoneFlag, addrSlaveFlag, busy, arbLostFlag;
        logic slaveDirFlag, irqPendFlag, recvAckFlag;
        logic own, addrPend, mAddr, active, roleTx, addrCyc;
        logic tenFirst, hdrHit, sdaLow, sclLow, sclHold;
        logic [3:0]  bitCnt;
        logic [7:0]  shift;
        logic [7:0]  rxData;
        logic [15:0] cnt;
        tws_gen_e    gen;
        tws_apb_rsp_s rsp;
        tws_pin_out_s pin;
    } tws_state_s;
endpackage : tws_pkg

// file: design/tws_top.sv
// Two-wire bus status, data and address-extension logic with APB registers
`timescale 1ns/1ps
`include "tws_defs.svh"
module tws_top #(
    parameter logic [15:0] HALF = 16'(`TWS_SCL_HALF_CYC)
) (
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    input  wire logic            ce,
    input  tws_pkg::tws_apb_req_s apbReq,
    output tws_pkg::tws_apb_rsp_s apbRsp,
    input  tws_pkg::tws_pin_in_s  pinIn,
    output tws_pkg::tws_pin_out_s pinOut
);
    import tws_pkg::*;

    tws_state_s s;
    tws_state_s next_s;

    logic       sclBus;
    logic       sdaBus;
    logic       sclRise;
    logic       sclFall;
    logic       startDet;
    logic       stopDet;
    logic       acc;
    logic       done;
    logic       wrDone;
    logic       rdDone;
    logic       wrSts;
    logic       wrData;
    logic       rdData;
    logic       wrCtl1;
    logic       wrCtl2;
    logic       wrAdr;
    logic [7:0] wd;
    logic       canGo;
    logic       halfUp;
    logic       gcHit;
    logic       m7;
    logic       tenHdr;
    logic       tenLo;
    logic       tenRd;
    logic       hdrOnly;
    logic       match;
    logic       byteDone;
    logic       lose;
    logic [7:0] statusByte;

    // Synchronised line levels and their edges
    assign sclBus = s.sclS2;
    assign sdaBus = s.sdaS2;
    assign sclRise = s.sclS2 & ~s.sclQ;
    assign sclFall = ~s.sclS2 & s.sclQ;
    assign startDet = s.sclS2 & s.sclQ & s.sdaQ & ~s.sdaS2;
    assign stopDet = s.sclS2 & s.sclQ & ~s.sdaQ & s.sdaS2;

    // APB phases and register strobes
    assign acc = apbReq.psel & apbReq.penable & ~s.rsp.pready;
    assign done = apbReq.psel & apbReq.penable & s.rsp.pready;
    assign wrDone = done & apbReq.pwrite & apbReq.pstrb[0];
    assign rdDone = done & ~apbReq.pwrite;
    assign wd = apbReq.pwdata[7:0];
    assign wrSts = wrDone & (apbReq.paddr == `TWS_OFS_STATUS);
    assign wrData = wrDone & (apbReq.paddr == `TWS_OFS_DATA);
    assign wrCtl2 = wrDone & (apbReq.paddr == `TWS_OFS_CTRL2);
    assign wrCtl1 = wrDone & (apbReq.paddr == `TWS_OFS_CTRL1);
    assign wrAdr = wrDone & (apbReq.paddr == `TWS_OFS_SLVADR);
    assign rdData = rdDone & (apbReq.paddr == `TWS_OFS_DATA);

    // transfers need bus ownership or a matched address
    assign canGo = s.en & ~s.active & ((s.own & s.gen == G_IDLE) | s.addrSlaveFlag);
    assign halfUp = (s.cnt == HALF - 16'd1);

    assign gcHit = s.genCallEn & (s.shift == 8'h00);
    assign m7 = ~s.wideAddrSel & (s.shift[7:1] == s.slvAdr[7:1]);
    // upper bits used only when wide
    assign tenHdr = s.wideAddrSel & (s.shift[7:1] == {`TWS_TEN_HDR, s.adHi[1:0]});
    assign tenLo = s.wideAddrSel & s.tenFirst & (s.shift == s.slvAdr);
    assign tenRd = tenHdr & s.shift[0] & s.addrSlaveFlag;
    assign hdrOnly = tenHdr & ~s.shift[0] & ~s.tenFirst;
    assign match = gcHit | m7 | tenLo | tenRd | hdrOnly;

    // Byte ends on the fall after the ninth clock
    assign byteDone = sclFall & s.active & (s.bitCnt == 4'd9);
    // we released SDA but the bus reads low
    assign lose = sclRise & s.active & s.own & s.roleTx & (s.bitCnt < 4'd8) & ~s.sdaLow & ~sdaBus;

    assign statusByte = {s.byteDoneFlag, s.addrSlaveFlag, s.busy, s.arbLostFlag,
                         1'b0, s.slaveDirFlag, s.irqPendFlag, s.recvAckFlag};

    // Next state of the whole block
    always_comb begin
        next_s = s;
        // Two-stage synchronisers, then edge history
        next_s.sdaS1 = pinIn.sda;
        next_s.sdaS2 = s.sdaS1;
        next_s.sdaQ = s.sdaS2;
        next_s.sclS1 = pinIn.scl;
        next_s.sclS2 = s.sclS1;
        next_s.sclQ = s.sclS2;

        // APB answer: one wait cycle, data ready with pready
        next_s.rsp.pready = 1'b0;
        next_s.rsp.pslverr = 1'b0;
        if (acc) begin
            next_s.rsp.pready = 1'b1;
            next_s.rsp.prdata = 32'h0;
            case (apbReq.paddr)
                `TWS_OFS_STATUS: next_s.rsp.prdata[7:0] = statusByte;
                `TWS_OFS_DATA: next_s.rsp.prdata[7:0] = s.rxData;
                `TWS_OFS_CTRL2: next_s.rsp.prdata[7:0] = {s.genCallEn, s.wideAddrSel, 3'b000, s.adHi};
                `TWS_OFS_CTRL1: next_s.rsp.prdata[7:0] = {s.en, 1'b0, s.masterSel, s.tx, s.txak, 3'b000};
                `TWS_OFS_SLVADR: next_s.rsp.prdata[7:0] = s.slvAdr;
                default: next_s.rsp.pslverr = 1'b1;
            endcase
        end

        // Register writes
        if (wrCtl1) begin
            next_s.en = wd[`TWS_C1_EN];
            next_s.masterSel = wd[`TWS_C1_MST];
            next_s.tx = wd[`TWS_C1_TX];
            next_s.txak = wd[`TWS_C1_TXAK];
            next_s.addrSlaveFlag = 1'b0;
        end
        if (wrCtl2) begin
            next_s.genCallEn = wd[`TWS_C2_GCE];
            next_s.wideAddrSel = wd[`TWS_C2_WIDE];
            next_s.adHi = wd[2:0];
        end
        if (wrAdr) begin
            next_s.slvAdr = wd;
        end
        if (wrSts) begin
            if (wd[`TWS_ST_ARB]) begin
                next_s.arbLostFlag = 1'b0;
            end
            if (wd[`TWS_ST_IRQ]) begin
                next_s.irqPendFlag = 1'b0;
            end
        end

        // data write starts transmit; first write is address
        if (wrData && (s.tx || s.addrPend)) begin
            next_s.byteDoneFlag = 1'b0;
            if (canGo) begin
                next_s.shift = wd;
                next_s.active = 1'b1;
                next_s.roleTx = 1'b1;
                next_s.bitCnt = 4'd0;
                next_s.sdaLow = ~wd[7];
                next_s.sclHold = 1'b0;
                next_s.mAddr = s.addrPend;
                next_s.addrPend = 1'b0;
            end
        end
        // data read starts reception; only in receive
        if (rdData && !s.tx) begin
            next_s.byteDoneFlag = 1'b0;
            if (canGo && !s.addrPend) begin
                next_s.active = 1'b1;
                next_s.roleTx = 1'b0;
                next_s.bitCnt = 4'd0;
                next_s.sdaLow = 1'b0;
                next_s.sclHold = 1'b0;
            end
        end

        // Master clock, start and stop generator
        case (s.gen)
            G_IDLE: begin
                next_s.cnt = 16'd0;
                if (s.masterSel && !s.own && !s.busy && s.en) begin
                    next_s.sdaLow = 1'b1;
                    next_s.gen = G_START;
                end else if (!s.masterSel && s.own) begin
                    next_s.own = 1'b0;
                    next_s.sdaLow = 1'b1;
                    next_s.sclLow = 1'b1;
                    next_s.gen = G_STOP1;
                end else if (s.own && s.active) begin
                    next_s.gen = G_LOW;
                end
            end
            G_START: begin
                next_s.cnt = s.cnt + 16'd1;
                if (halfUp) begin
                    next_s.sclLow = 1'b1;
                    next_s.own = 1'b1;
                    next_s.addrPend = 1'b1;
                    next_s.gen = G_IDLE;
                end
            end
            G_LOW: begin
                next_s.cnt = s.cnt + 16'd1;
                if (!s.active) begin
                    next_s.gen = G_IDLE;
                end else if (halfUp) begin
                    next_s.sclLow = 1'b0;
                    next_s.cnt = 16'd0;
                    next_s.gen = G_HIGH;
                end
            end
            // High phase counts only once the line is high
            G_HIGH: begin
                if (sclBus) begin
                    next_s.cnt = s.cnt + 16'd1;
                    if (halfUp) begin
                        next_s.sclLow = 1'b1;
                        next_s.cnt = 16'd0;
                        next_s.gen = G_IDLE;
                    end
                end
            end
            G_STOP1: begin
                next_s.cnt = s.cnt + 16'd1;
                if (halfUp) begin
                    next_s.sclLow = 1'b0;
                    next_s.cnt = 16'd0;
                    next_s.gen = G_STOP2;
                end
            end
            G_STOP2: begin
                if (sclBus) begin
                    next_s.cnt = s.cnt + 16'd1;
                    if (halfUp) begin
                        next_s.sdaLow = 1'b0;
                        next_s.gen = G_IDLE;
                    end
                end
            end
            default: next_s.gen = G_IDLE;
        endcase

        // busy on start, idle on stop
        if (startDet) begin
            next_s.busy = 1'b1;
            next_s.bitCnt = 4'd0;
            // Arm for an address byte unless this is our own start
            if (!s.own && s.gen != G_START && s.en) begin
                next_s.active = 1'b1;
                next_s.roleTx = 1'b0;
                next_s.addrCyc = 1'b1;
                next_s.tenFirst = 1'b0;
                next_s.hdrHit = 1'b0;
                next_s.sdaLow = 1'b0;
                next_s.sclHold = 1'b0;
            end
        end
        if (stopDet) begin
            next_s.busy = 1'b0;
            if (!s.own) begin
                next_s.active = 1'b0;
                next_s.sdaLow = 1'b0;
                next_s.sclHold = 1'b0;
            end
        end

        // Sample on the rising clock edge
        if (sclRise && s.active && s.bitCnt < 4'd9) begin
            next_s.bitCnt = s.bitCnt + 4'd1;
            if (s.bitCnt < 4'd8) begin
                next_s.shift = {s.shift[6:0], sdaBus};
            end else if (s.roleTx) begin
                next_s.recvAckFlag = sdaBus;
            end
        end

        // Drive on the falling clock edge
        if (sclFall && s.active) begin
            if (s.bitCnt > 4'd0 && s.bitCnt < 4'd8) begin
                next_s.sdaLow = s.roleTx & ~s.shift[7];
            end else if (s.bitCnt == 4'd8) begin
                // receiver pulls SDA low on ninth clock
                if (s.roleTx) begin
                    next_s.sdaLow = 1'b0;
                end else if (s.addrCyc && !s.own) begin
                    next_s.sdaLow = match;
                    next_s.hdrHit = match;
                    if (match && !hdrOnly) begin
                        next_s.slaveDirFlag = s.shift[0] & ~gcHit;
                    end
                end else begin
                    next_s.sdaLow = ~s.txak;
                end
            end
        end

        // Byte completion
        if (byteDone) begin
            next_s.sdaLow = 1'b0;
            next_s.bitCnt = 4'd0;
            if (s.addrCyc && !s.own) begin
                if (s.hdrHit && hdrOnly) begin
                    next_s.tenFirst = 1'b1;
                    next_s.hdrHit = 1'b0;
                end else begin
                    next_s.active = 1'b0;
                    if (s.hdrHit) begin
                        next_s.addrSlaveFlag = 1'b1;
                        next_s.irqPendFlag = 1'b1;
                        next_s.byteDoneFlag = 1'b1;
                        next_s.addrCyc = 1'b0;
                        next_s.rxData = s.shift;
                        next_s.sclHold = 1'b1;
                    end
                end
            end else begin
                next_s.byteDoneFlag = 1'b1;
                next_s.irqPendFlag = 1'b1;
                next_s.active = 1'b0;
                next_s.mAddr = 1'b0;
                if (!s.roleTx) begin
                    next_s.rxData = s.shift;
                end
                // Slave stretches the clock until software acts
                next_s.sclHold = ~s.own;
            end
        end

        // lost master stops driving, no stop generated
        if (lose) begin
            next_s.arbLostFlag = 1'b1;
            next_s.irqPendFlag = 1'b1;
            next_s.masterSel = 1'b0;
            next_s.own = 1'b0;
            next_s.roleTx = 1'b0;
            next_s.addrCyc = s.mAddr;
            next_s.sdaLow = 1'b0;
            next_s.sclLow = 1'b0;
            next_s.gen = G_IDLE;
        end

        // pins are only pulled low or released
        next_s.pin.sdaO = 1'b0;
        next_s.pin.sclO = 1'b0;
        next_s.pin.sdaOe_n = ~next_s.sdaLow;
        next_s.pin.sclOe_n = ~(next_s.sclLow | next_s.sclHold);
    end

    // State register, frozen while ce is low
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s <= '0;
            s.byteDoneFlag <= `TWS_DONE_RST;
            s.pin.sdaOe_n <= 1'b1;
            s.pin.sclOe_n <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign apbRsp = s.rsp;
    assign pinOut = s.pin;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence sStartSeen;
        ce && startDet;
    endsequence

    sequence sStopSeen;
        ce && stopDet && !startDet;
    endsequence

    a_busy_start: assert property (sStartSeen |=> s.busy)
        else $error("busy not set after start");
    a_busy_stop: assert property (sStopSeen |=> !s.busy)
        else $error("busy not cleared after stop");
    a_done_set: assert property (ce && byteDone && !(s.addrCyc && !s.own) |=> s.byteDoneFlag)
        else $error("done flag not set at byte end");
    a_done_clear: assert property (ce && wrData && s.tx && !byteDone |=> !s.byteDoneFlag)
        else $error("done flag not cleared by data write");
    a_arb_sticky: assert property (s.arbLostFlag && !(ce && wrSts && wd[`TWS_ST_ARB]) |=> s.arbLostFlag)
        else $error("loss flag dropped without a write");
    a_lose_release: assert property (ce && lose |=> !s.masterSel && s.pin.sdaOe_n && s.arbLostFlag)
        else $error("lost master still driving");
    a_slave_clear: assert property (ce && wrCtl1 && !byteDone |=> !s.addrSlaveFlag)
        else $error("slave flag survived control write");
    a_irq_events: assert property (ce && (byteDone || lose) && !(s.addrCyc && !s.own && !s.hdrHit)
                                   |=> s.irqPendFlag)
        else $error("pending flag not set on event");
    a_rx_guard: assert property (ce && rdData && s.tx && !s.active && !startDet |=> !s.active)
        else $error("read started reception in transmit");
    a_unused_zero: assert property (ce && acc && apbReq.paddr == `TWS_OFS_STATUS
                                    |=> s.rsp.pready && !s.rsp.prdata[3])
        else $error("unused status bit not zero");
    a_pin_drain: assert property (!s.pin.sdaO && !s.pin.sclO)
        else $error("pin drives high");
endmodule // tws_top

// file: bench/tws_slave_model.sv
// Slave device model hanging on the two-wire lines
`timescale 1ns/1ps
module tws_slave_model #(
    parameter logic [6:0] ADR = 7'h52
) (
    input  wire logic       sdaW,
    input  wire logic       sclW,
    input  wire logic       fight,
    input  wire logic [7:0] txByte,
    output logic            sdaPull,
    output logic [7:0]      adrByte,
    output logic [7:0]      rxByte
);
    logic       drv;
    logic       inFrame;
    logic [7:0] b;
    int         n;
    // Pull low only, contender holds data low
    assign sdaPull = drv | (fight & inFrame);
    always @(sdaW) if (sclW === 1'b1) inFrame = !sdaW;
    // Eight rising clocks, msb first
    task automatic getb;
        for (int i = 0; i < 8; i++) begin
            @(posedge sclW) b = {b[6:0], sdaW};
        end
    endtask
    // Acknowledge slot on the ninth clock
    task automatic ack(input logic a, input logic nxt);
        @(negedge sclW) #200 drv = a;
        @(negedge sclW) #200 drv = nxt;
    endtask
    initial begin
        drv = 0;
        inFrame = 0;
        adrByte = 0;
        rxByte = 0;
        b = 0;
        forever begin : run
            drv = 0;
            @(negedge sdaW iff sclW === 1'b1);
            getb();
            adrByte = b;
            if (b[7:1] != ADR) disable run;
            n = 0;
            if (b[0]) begin
                ack(1'b1, !txByte[7]);
                for (int i = 6; i >= 0; i--) begin
                    @(negedge sclW) #200 drv = !txByte[i];
                end
                @(negedge sclW) #200 drv = 0;
                @(posedge sdaW iff sclW === 1'b1);
            end else begin
                ack(1'b1, 1'b0);
                forever begin
                    getb();
                    rxByte = b;
                    n++;
                    ack(n < 2, 1'b0);
                end
            end
        end
    end
    always @(posedge sdaW) if (sclW === 1'b1) disable run;
endmodule // tws_slave_model

// file: bench/testbench.sv
// Self-checking bench for the two-wire bus block
`timescale 1ns/1ps
`include "tws_defs.svh"
module testbench;
    import tws_pkg::*;
    typedef struct {
        logic       wr;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] exp;
        logic       err;
    } tws_row_s;
    localparam logic [7:0] ST = `TWS_OFS_STATUS;
    localparam logic [7:0] DA = `TWS_OFS_DATA;
    localparam logic [7:0] C1 = `TWS_OFS_CTRL1;
    localparam logic [7:0] C2 = `TWS_OFS_CTRL2;
    logic         clk_sys;
    logic         rst_n;
    logic         fight;
    logic         slvPull;
    logic         e;
    logic [7:0]   adrByte;
    logic [7:0]   rxByte;
    logic [31:0]  v;
    tws_apb_req_s req;
    tws_apb_rsp_s rsp;
    tws_pin_out_s pinOut;
    tws_row_s     rows[9];
    int           error_cnt;
    int           checked;
    int           cyc;
    wire logic    sdaW = pinOut.sdaOe_n & !slvPull;
    wire logic    sclW = pinOut.sclOe_n;
    tws_top #(.HALF(16'h0008)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .apbReq(req), .apbRsp(rsp),
        .pinIn({sdaW, sclW}), .pinOut(pinOut));
    tws_slave_model #(.ADR(7'h52)) SLV (.sdaW(sdaW), .sclW(sclW), .fight(fight), .txByte(8'h5a),
        .sdaPull(slvPull), .adrByte(adrByte), .rxByte(rxByte));
    // Clock
    initial begin
        clk_sys = 0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic close_out;
        $display("Checks %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, wr, a, {24'h0, d}, 4'hf};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        // Hold the request until pready is seen at a rising edge
        do begin
            @(posedge clk_sys);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        v = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
        @(posedge clk_sys);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(nm, v, {24'h0, exp});
    endtask
    task automatic waitDone;
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, ST, 8'h00);
            if (v[7] === 1'b1) return;
        end
        chk("done", 0, 1);
    endtask
    initial begin
        rst_n = 1'b0;
        fight = 1'b0;
        req = '0;
        rows = '{'{0, ST, 0, 8'h80, 0}, '{1, C2, 8'hff, 0, 0}, '{0, C2, 0, 8'hc7, 0}, '{1, ST, 8'hff, 0, 0},
            '{0, ST, 0, 8'h80, 0}, '{1, 8'h14, 8'h55, 0, 1}, '{0, 8'h14, 0, 0, 1}, '{1, C2, 8'h41, 0, 0},
            '{1, `TWS_OFS_SLVADR, 8'h20, 0, 0}};
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            chk("pslverr", e, rows[i].err);
            if (!rows[i].wr && !rows[i].err) chk("rdata", v, {24'h0, rows[i].exp});
        end
        // Reset in mid-run
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rdc("c2rst", C2, 8'h00);
        rdc("strst", ST, 8'h80);
        chk("sdaRel", pinOut.sdaOe_n, 1'b1);
        apb(1'b1, `TWS_OFS_SLVADR, 8'h20);
        // Master transmit
        apb(1'b1, C1, 8'hb0);
        repeat (6) @(posedge clk_sys);
        rdc("busy", ST, 8'ha0);
        apb(1'b1, DA, 8'ha4);
        waitDone();
        chk("addr", adrByte, 8'ha4);
        rdc("st", ST, 8'ha2);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, ST, 8'h02);
            apb(1'b1, DA, i ? 8'hc3 : 8'h3c);
            rdc("run", ST, 8'h20);
            waitDone();
            chk("rx", rxByte, i ? 8'hc3 : 8'h3c);
            rdc("ack", ST, i ? 8'ha3 : 8'ha2);
        end
        apb(1'b0, DA, 8'h00);
        repeat (40) @(posedge clk_sys);
        rdc("norx", ST, 8'ha3);
        apb(1'b1, C1, 8'h90);
        repeat (60) @(posedge clk_sys);
        apb(1'b0, ST, 8'h00);
        chk("idle", v[5], 1'b0);
        // Master receive, one byte
        apb(1'b1, ST, 8'h02);
        apb(1'b1, C1, 8'hb0);
        repeat (6) @(posedge clk_sys);
        apb(1'b1, DA, 8'ha5);
        waitDone();
        apb(1'b1, C1, 8'ha8);
        apb(1'b0, DA, 8'h00);
        rdc("rxrun", ST, 8'h22);
        waitDone();
        apb(1'b1, C1, 8'h88);
        rdc("rxd", DA, 8'h5a);
        repeat (60) @(posedge clk_sys);
        // Lost arbitration on the address byte
        apb(1'b1, ST, 8'h02);
        fight <= 1'b1;
        apb(1'b1, C1, 8'hb0);
        repeat (6) @(posedge clk_sys);
        apb(1'b1, DA, 8'ha4);
        repeat (80) @(posedge clk_sys);
        apb(1'b0, ST, 8'h00);
        chk("lost", {v[4], v[1]}, 2'b11);
        chk("sdaOff", pinOut.sdaOe_n, 1'b1);
        fight <= 1'b0;
        apb(1'b1, ST, 8'h10);
        apb(1'b0, ST, 8'h00);
        chk("arbClr", v[4], 1'b0);
        close_out();
    end
endmodule // testbench
